// *** shared/dram_cmd_pkg.sv ***
// constants, types and pin decoding shared by the command decoder files
package dram_cmd_pkg;

  localparam int AP_BIT         = 10;
  localparam int BC_BIT         = 12;
  localparam int COL_LOW_W      = 10;
  localparam int COL_HIGH_BIT   = 11;
  localparam int COL_W          = COL_LOW_W + 1;
  localparam int MIN_ADDR_W     = 13;
  localparam int MR_BL_LSB      = 0;
  localparam int MR_BL_W        = 2;
  localparam int MR0_SELECT     = 0;
  localparam int BEATS_FULL     = 8;
  localparam int BEATS_CHOP     = 4;
  localparam int BEATS_PER_CLK  = 2;
  localparam int CNT_W          = 3;

  localparam logic [MR_BL_W-1:0] MR_BL_FIXED8 = 2'h0;
  localparam logic [MR_BL_W-1:0] MR_BL_OTF    = 2'h1;
  localparam logic [MR_BL_W-1:0] MR_BL_FIXED4 = 2'h2;
  localparam logic [MR_BL_W-1:0] MR_BL_RESET  = MR_BL_FIXED8;
  localparam logic [CNT_W-1:0]   FULL_CLKS    = CNT_W'(BEATS_FULL / BEATS_PER_CLK);
  localparam logic [CNT_W-1:0]   CHOP_CLKS    = CNT_W'(BEATS_CHOP / BEATS_PER_CLK);
  localparam logic               CKE_PREV_RESET = 1'b0;

  typedef enum logic [1:0] {mode_normal, mode_power_down, mode_self_refresh} power_state_t;

  typedef enum logic [3:0] {
    deselect_cmd, no_operation_cmd, mode_register_set_cmd, refresh_cmd,
    self_refresh_entry_cmd, self_refresh_exit_cmd, bank_precharge_cmd, all_bank_precharge_cmd,
    bank_activate_cmd, write_cmd, read_cmd, power_down_entry_cmd,
    power_down_exit_cmd, impedance_cal_long_cmd, impedance_cal_short_cmd, illegal_cmd
  } cmd_t;

  // nop or deselect: with refresh on a falling clock enable, the only patterns allowed beside a clock-enable transition
  function automatic logic is_quiet(input logic cs_n, input logic ras_n, input logic cas_n,
                                    input logic we_n);
    return cs_n || (ras_n && cas_n && we_n);
  endfunction

  function automatic logic is_refresh(input logic cs_n, input logic ras_n, input logic cas_n,
                                      input logic we_n);
    return !cs_n && !ras_n && !cas_n && we_n;
  endfunction

  // command with clock enable high in both cycles
  function automatic cmd_t decode_active(input logic cs_n, input logic ras_n, input logic cas_n,
                                         input logic we_n, input logic ap);
    cmd_t c;
    c = illegal_cmd;
    if (cs_n)
      c = deselect_cmd;
    else
      case ({ras_n, cas_n, we_n})
        3'h0:    c = mode_register_set_cmd;
        3'h1:    c = refresh_cmd;
        3'h2:    c = ap ? all_bank_precharge_cmd : bank_precharge_cmd;
        3'h3:    c = bank_activate_cmd;
        3'h4:    c = write_cmd;
        3'h5:    c = read_cmd;
        3'h6:    c = ap ? impedance_cal_long_cmd : impedance_cal_short_cmd;
        3'h7:    c = no_operation_cmd;
        default: c = illegal_cmd;
      endcase
    return c;
  endfunction

endpackage

// *** hdl/burst_tracker.sv ***
// burst occupancy tracker: once started a burst runs to its end
`timescale 1ns/1ps
`default_nettype none
module burst_tracker
  import dram_cmd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic start_chop4,
  input  wire logic start_write,
  input  wire logic start_autoclose,
  output logic      busy,
  output logic      is_write,
  output logic      precharge_due
);
  import dram_cmd_pkg::*;

  logic [CNT_W-1:0] remain_reg;
  logic             write_reg;
  logic             autoclose_reg;
  logic             due_reg;
  logic             take;

  // a new burst is only taken on the last cycle or after; nothing cuts one short
  assign take = start && (remain_reg <= CNT_W'(1));  // [R9]

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      remain_reg <= '0;
    else if (take)
      remain_reg <= start_chop4 ? CHOP_CLKS : FULL_CLKS;  // [R7]
    else if (remain_reg != '0)
      remain_reg <= remain_reg - CNT_W'(1);  // [R9]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      write_reg     <= 1'b0;
      autoclose_reg <= 1'b0;
    end
    else if (take)
    begin
      write_reg     <= start_write;
      autoclose_reg <= start_autoclose;
    end
  end

  // auto-precharge of the bank is requested as the burst finishes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      due_reg <= 1'b0;
    else
      due_reg <= autoclose_reg && (remain_reg == CNT_W'(1));  // [R6]
  end

  assign busy          = remain_reg != '0;
  assign is_write      = write_reg;
  assign precharge_due = due_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  burst_runs_full_a: assert property ((take && !start_chop4 && remain_reg == '0)  // [R9]
    |=> busy [*4] ##1 (!busy || $past(take))) else $error("full burst did not run four clocks");
  burst_runs_chop_a: assert property ((take && start_chop4) |=> busy ##1 busy)
    else $error("chopped burst ended early");  // [R7]

endmodule
`default_nettype wire

// *** hdl/dram_command_decoder.sv ***
// command decoder: registers the command pins and resolves them into commands
//
// Notes on behaviour
// [R1] commands decoded from pins at rising clock
// [R2] reset pin held high except forced reset
// [R3] bank selects bank, or mode register
// [R4] write: cs low, ras high, cas/we low
// [R5] read: as write with we high
// [R6] auto-precharge bit requests close after burst
// [R7] on-the-fly: chop bit low four beats
// [R8] mode register picks fixed or on-the-fly
// [R9] started bursts always run to completion
// [R10] precharge: one bank, or all with bit
// [R11] calibration long or short by bit
// [R12] nop registers nothing, ends nothing
// [R13] controller idles with nop commands
// [R14] deselect ignores other pins, acts as nop
// [R15] power-down entry and exit on clock enable
// [R16] refresh with clock enable falling: self-refresh
// [R17] termination ignored in decode, off in self-refresh
// [R18] controller waits 512 clocks before writing; the model waits only after a self-refresh exit
// [R19] activate, refresh and mode set encodings
// [R20] only nop/deselect, or refresh as clock enable falls, beside clock-enable edges
// [R21] self-refresh only with all banks idle; the decoder does not check bank state
`timescale 1ns/1ps
`default_nettype none
module dram_command_decoder
  import dram_cmd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int BANK_W = 3
)
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic                    cke,
  input  wire logic [BANK_W-1:0]       bank_address,
  input  wire logic [ADDR_W-1:0]       address,
  input  wire logic                    termination_control,
  output logic                         cmd_valid,
  output dram_cmd_pkg::cmd_t           cmd_code,
  output logic [BANK_W-1:0]            cmd_bank,
  output logic [ADDR_W-1:0]            cmd_row,
  output logic [dram_cmd_pkg::COL_W-1:0] cmd_column,
  output logic                         cmd_auto_precharge,
  output logic                         cmd_chop4,
  output logic                         cmd_all_banks,
  output logic                         mr_write,
  output logic [BANK_W-1:0]            mr_select,
  output logic [ADDR_W-1:0]            mr_opcode,
  output logic                         burst_otf_enable,
  output dram_cmd_pkg::power_state_t   power_state,
  output logic                         burst_busy,
  output logic                         burst_is_write,
  output logic                         auto_precharge_due,
  output logic                         termination_enable
);
  import dram_cmd_pkg::*;

  if (ADDR_W < MIN_ADDR_W || ADDR_W > 16)
    $error("ADDR_W must lie between 13 and 16");
  if (BANK_W < 1 || BANK_W > 3)
    $error("BANK_W must lie between 1 and 3");

  power_state_t            state_reg;
  power_state_t            state_next;
  logic                    cke_prev_reg;
  cmd_t                    code_reg;
  cmd_t                    code_next;
  logic                    valid_reg;
  logic                    valid_next;
  logic [BANK_W-1:0]       bank_reg;
  logic [ADDR_W-1:0]       row_reg;
  logic [COL_W-1:0]        column_reg;
  logic                    ap_reg;
  logic                    chop_reg;
  logic                    chop_next;
  logic                    all_reg;
  logic [MR_BL_W-1:0]      mr_bl_reg;
  logic                    term_reg;
  logic                    quiet;
  logic                    burst_start;
  logic                    otf;

  assign quiet = is_quiet(cs_n, ras_n, cas_n, we_n);  // [R14]
  assign otf   = mr_bl_reg == MR_BL_OTF;  // [R8]

  // chop bit counts only in on-the-fly mode; fixed mode follows the mode register
  assign chop_next = otf ? !address[BC_BIT] : (mr_bl_reg == MR_BL_FIXED4);  // [R7] [R8]

  // power state and command resolution; clock enable is judged over two edges
  always_comb
  begin
    state_next = state_reg;
    code_next  = deselect_cmd;
    case (state_reg)
      mode_normal:
        if (!cke_prev_reg)
          code_next = deselect_cmd;
        else if (cke)
          code_next = decode_active(cs_n, ras_n, cas_n, we_n, address[AP_BIT]);  // [R1] [R19] [R4] [R5] [R10] [R11]
        else if (quiet)
        begin
          code_next  = power_down_entry_cmd;  // [R15]
          state_next = mode_power_down;
        end
        else if (is_refresh(cs_n, ras_n, cas_n, we_n))
        begin
          code_next  = self_refresh_entry_cmd;  // [R16]
          state_next = mode_self_refresh;
        end
        else
          code_next = illegal_cmd;
      mode_power_down:
        if (cke && quiet)
        begin
          code_next  = power_down_exit_cmd;  // [R15]
          state_next = mode_normal;
        end
        else if (cke)
          code_next = illegal_cmd;
      mode_self_refresh:
        if (cke && quiet)
        begin
          code_next  = self_refresh_exit_cmd;  // [R16]
          state_next = mode_normal;
        end
        else if (cke)
          code_next = illegal_cmd;
      default:
        state_next = mode_normal;
    endcase
  end

  // nop and deselect leave nothing registered and disturb no running burst
  assign valid_next = (code_next != deselect_cmd) && (code_next != no_operation_cmd);  // [R12] [R13] [R14]

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= mode_normal;
      cke_prev_reg <= CKE_PREV_RESET;
    end
    else
    begin
      state_reg    <= state_next;
      cke_prev_reg <= cke;  // [R1]
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_reg  <= deselect_cmd;
      valid_reg <= 1'b0;
    end
    else
    begin
      code_reg  <= code_next;
      valid_reg <= valid_next;
    end
  end

  // fields latch only with a real command so a nop leaves the last one standing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bank_reg   <= '0;
      row_reg    <= '0;
      column_reg <= '0;
      ap_reg     <= 1'b0;
      chop_reg   <= 1'b0;
      all_reg    <= 1'b0;
    end
    else if (valid_next)
    begin
      bank_reg   <= bank_address;  // [R3]
      row_reg    <= address;
      column_reg <= {address[COL_HIGH_BIT], address[COL_LOW_W-1:0]};  // [R4]
      ap_reg     <= (code_next == write_cmd || code_next == read_cmd) && address[AP_BIT];  // [R6]
      chop_reg   <= (code_next == write_cmd || code_next == read_cmd) && chop_next;  // [R7]
      all_reg    <= code_next == all_bank_precharge_cmd;  // [R10]
    end
  end

  // only the burst-length field of mode register 0 steers the decoder
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mr_bl_reg <= MR_BL_RESET;
    else if (code_next == mode_register_set_cmd && bank_address == BANK_W'(MR0_SELECT))
      mr_bl_reg <= address[MR_BL_LSB +: MR_BL_W];  // [R3] [R8]
  end

  // termination pin never enters decoding; it is gated off in self-refresh
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      term_reg <= 1'b0;
    else
      term_reg <= termination_control && (state_next != mode_self_refresh);  // [R17]
  end

  assign burst_start = code_next == write_cmd || code_next == read_cmd;

  burst_tracker u_burst (
    .clk             (clk),
    .nrst            (nrst),
    .start           (burst_start),
    .start_chop4     (chop_next),
    .start_write     (code_next == write_cmd),
    .start_autoclose (address[AP_BIT]),
    .busy            (burst_busy),
    .is_write        (burst_is_write),
    .precharge_due   (auto_precharge_due)
  );

  assign cmd_valid          = valid_reg;
  assign cmd_code           = code_reg;
  assign cmd_bank           = bank_reg;
  assign cmd_row            = row_reg;
  assign cmd_column         = column_reg;
  assign cmd_auto_precharge = ap_reg;
  assign cmd_chop4          = chop_reg;
  assign cmd_all_banks      = all_reg;
  assign mr_write           = valid_reg && code_reg == mode_register_set_cmd;
  assign mr_select          = bank_reg;
  assign mr_opcode          = row_reg;
  assign burst_otf_enable   = otf;
  assign power_state        = state_reg;
  assign termination_enable = term_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  write_decode_a: assert property ((state_reg == mode_normal && cke_prev_reg && cke && !cs_n && ras_n && !cas_n && !we_n)
    |=> cmd_valid && cmd_code == write_cmd) else $error("write not decoded");  // [R4]
  read_decode_a: assert property ((state_reg == mode_normal && cke_prev_reg && cke && !cs_n && ras_n && !cas_n && we_n)
    |=> cmd_code == read_cmd && cmd_bank == $past(bank_address)) else $error("read not decoded");  // [R5]
  nop_quiet_a: assert property ((!cs_n && ras_n && cas_n && we_n && cke && cke_prev_reg)
    |=> !cmd_valid && $stable(cmd_row)) else $error("nop registered a command");  // [R12]
  deselect_quiet_a: assert property ((cs_n && cke && cke_prev_reg && state_reg == mode_normal)
    |=> cmd_code == deselect_cmd && !cmd_valid) else $error("deselect not ignored");  // [R14]
  autoclose_flag_a: assert property ((cmd_valid && (cmd_code == write_cmd || cmd_code == read_cmd))
    |-> cmd_auto_precharge == $past(address[AP_BIT])) else $error("auto-precharge flag wrong");  // [R6]
  fixed_chop_a: assert property ((mr_bl_reg == MR_BL_FIXED8 && burst_start && state_reg == mode_normal)
    |=> !cmd_chop4) else $error("chop bit honoured in fixed mode");  // [R8]
  all_bank_precharge_cmd_all_a: assert property ((cmd_valid && cmd_code inside {bank_precharge_cmd, all_bank_precharge_cmd})
    |-> cmd_all_banks == $past(address[AP_BIT])) else $error("precharge scope wrong");  // [R10]
  zq_kind_a: assert property ((cmd_valid && cmd_code inside {impedance_cal_long_cmd, impedance_cal_short_cmd})
    |-> (cmd_code == impedance_cal_long_cmd) == $past(address[AP_BIT])) else $error("calibration kind wrong");  // [R11]
  pd_cycle_a: assert property ((state_reg == mode_normal && cke_prev_reg && !cke && quiet)
    |=> power_state == mode_power_down && cmd_code == power_down_entry_cmd) else $error("power-down not entered");  // [R15]
  sr_entry_a: assert property ((state_reg == mode_normal && cke_prev_reg && !cke && !cs_n && !ras_n && !cas_n && we_n)
    |=> power_state == mode_self_refresh && !termination_enable) else $error("self-refresh entry wrong");  // [R16] [R17]

  sr_round_c: cover property (power_state == mode_normal ##1 power_state == mode_self_refresh [*3]
    ##1 power_state == mode_normal);
  pd_round_c: cover property (cmd_code == power_down_entry_cmd ##[1:20] cmd_code == power_down_exit_cmd);
  back_to_back_c: cover property (cmd_code == write_cmd && cmd_valid ##4 cmd_code == read_cmd && cmd_valid);

endmodule
`default_nettype wire

// *** testbench/ctrl_model.sv ***
// controller-side model that drives the command, clock-enable and address pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import dram_cmd_pkg::*;
(
  input  wire logic        clk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             cke,
  output logic [2:0]       bank_address,
  output logic [15:0]      address
);
  int unsigned since_wake = 512;
  logic        in_self_refresh = 1'b0;

  always @(posedge clk)
    since_wake <= since_wake + 1;

  initial
  begin
    {cs_n, ras_n, cas_n, we_n, cke} = 5'h1f;
    bank_address = 3'h0;
    address = 16'h0000;
  end

  // one pin pattern per call, launched 1 ns after the edge and held to the next edge
  task automatic send(input logic [3:0] p, input logic ke, input logic [2:0] ba, input logic [15:0] a);
    @(posedge clk);
    if (p == 4'h4 && since_wake < 512)
      repeat (512 - since_wake) @(posedge clk);
    #1;
    // a clock-enable edge only travels with nop, deselect or a refresh going down
    if (ke !== cke && !is_quiet(p[3], p[2], p[1], p[0]) && !(is_refresh(p[3], p[2], p[1], p[0]) && !ke))
      p = 4'h7;
    // only a self-refresh exit starts the write wait; a power-down exit does not
    if (ke && !cke && in_self_refresh)
      since_wake = 0;
    if (ke !== cke)
      in_self_refresh = !ke && is_refresh(p[3], p[2], p[1], p[0]);
    {cs_n, ras_n, cas_n, we_n, cke} = {p, ke};
    // an unselected device sees floating lines, so never leave the old values standing
    bank_address = p[3] ? ~bank_address : ba;
    address = p[3] ? ~address : a;
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dram_cmd_pkg::*;
  localparam logic [3:0] P_MRS = 4'h0, P_REF = 4'h1, P_PRE = 4'h2, P_ACT = 4'h3, P_WR = 4'h4;
  localparam logic [3:0] P_RD = 4'h5, P_ZQ = 4'h6, P_NOP = 4'h7, P_DES = 4'h8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic term = 1'b1;
  logic cs_n, ras_n, cas_n, we_n, cke;
  logic [2:0] bank_address, cmd_bank, mr_select;
  logic [15:0] address, cmd_row, mr_opcode;
  logic [COL_W-1:0] cmd_column;
  logic cmd_valid, cmd_auto_precharge, cmd_chop4, cmd_all_banks, mr_write, burst_otf_enable;
  logic burst_busy, burst_is_write, auto_precharge_due, termination_enable;
  cmd_t cmd_code;
  power_state_t power_state;
  int n_errors = 0;
  int checks = 0;

  always #2 clk = ~clk;

  ctrl_model u_ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
                     .bank_address(bank_address), .address(address));

  dram_command_decoder #(.ADDR_W(16), .BANK_W(3)) dut (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
    .bank_address(bank_address), .address(address), .termination_control(term),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
    .cmd_column(cmd_column), .cmd_auto_precharge(cmd_auto_precharge), .cmd_chop4(cmd_chop4),
    .cmd_all_banks(cmd_all_banks), .mr_write(mr_write), .mr_select(mr_select), .mr_opcode(mr_opcode),
    .burst_otf_enable(burst_otf_enable), .power_state(power_state), .burst_busy(burst_busy),
    .burst_is_write(burst_is_write), .auto_precharge_due(auto_precharge_due),
    .termination_enable(termination_enable));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic cmd(input logic [3:0] p, input logic [2:0] ba, input logic [15:0] a);
    u_ctrl.send(p, 1'b1, ba, a);
  endtask

  // waiting time is filled with nops so nothing stray is registered
  task automatic idle(input int n);
    repeat (n) cmd(P_NOP, 3'h0, 16'h0000);
  endtask

  task automatic t_decode;
    logic [3:0] p [9] = '{P_MRS, P_REF, P_PRE, P_PRE, P_ACT, P_ZQ, P_ZQ, P_NOP, P_DES};
    logic [15:0] a [9] = '{16'h1234, 16'h0000, 16'h0000, 16'h0400, 16'h0abc, 16'h0400, 16'h0000, 16'hffff, 16'h0000};
    cmd_t e [9] = '{mode_register_set_cmd, refresh_cmd, bank_precharge_cmd, all_bank_precharge_cmd,
                    bank_activate_cmd, impedance_cal_long_cmd, impedance_cal_short_cmd, no_operation_cmd, deselect_cmd};
    for (int i = 0; i < 9; i++)
    begin
      term = i[0];
      cmd(p[i], (i == 0) ? 3'h2 : 3'h5, a[i]);
      cmd(P_NOP, 3'h0, 16'h0000);
      if (i < 7)
        chk(cmd_valid === 1'b1 && cmd_code === e[i], "command code");
      else
        chk(cmd_valid === 1'b0, "nop or deselect registered");
      if (i == 0)
        chk(mr_write === 1'b1 && mr_select === 3'h2 && mr_opcode === 16'h1234, "mode set fields");
      if (i == 2 || i == 3)
        chk(cmd_bank === 3'h5 && cmd_all_banks === (i == 3), "precharge scope");
      if (i == 4)
        chk(cmd_row === 16'h0abc && cmd_bank === 3'h5, "activate fields");
      chk(termination_enable === i[0], "termination pin not followed");
    end
    term = 1'b1;
    $display("decode table done");
  endtask

  task automatic t_write_burst;
    int nb;
    int due_at;
    nb = 1;
    due_at = 0;
    cmd(P_WR, 3'h3, 16'h0c05);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_valid === 1'b1 && cmd_code === write_cmd && cmd_bank === 3'h3, "write decode");
    chk(cmd_column === 11'h405 && cmd_auto_precharge === 1'b1 && cmd_chop4 === 1'b0, "write fields");
    chk(burst_busy === 1'b1 && burst_is_write === 1'b1, "write burst start");
    for (int k = 1; k < 8; k++)
    begin
      cmd((k == 1) ? P_RD : P_NOP, 3'h1, 16'h0000);
      if (k == 2)
        chk(cmd_code === read_cmd && burst_busy === 1'b1 && burst_is_write === 1'b1, "burst cut");
      if (burst_busy === 1'b1)
        nb++;
      if (auto_precharge_due === 1'b1)
        due_at = due_at * 10 + k;
    end
    chk(nb == 4 && due_at == 4, "eight-beat length or auto close");
    $display("write burst done");
  endtask

  task automatic t_burst_length;
    cmd(P_MRS, 3'h0, 16'h0001);
    idle(2);
    chk(burst_otf_enable === 1'b1, "on-the-fly not set");
    cmd(P_RD, 3'h2, 16'h0000);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_code === read_cmd && cmd_chop4 === 1'b1 && burst_is_write === 1'b0, "chopped read");
    idle(2);
    chk(burst_busy === 1'b0 && cmd_auto_precharge === 1'b0, "chopped read length");
    cmd(P_RD, 3'h2, 16'h1400);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_chop4 === 1'b0 && cmd_auto_precharge === 1'b1, "full read");
    idle(5);
    cmd(P_MRS, 3'h0, 16'h0002);
    idle(2);
    cmd(P_WR, 3'h2, 16'h1000);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(burst_otf_enable === 1'b0 && cmd_chop4 === 1'b1, "fixed four ignores bit");
    idle(3);
    cmd(P_MRS, 3'h0, 16'h0000);
    idle(2);
    cmd(P_RD, 3'h2, 16'h0000);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_chop4 === 1'b0, "fixed eight ignores bit");
    idle(5);
    $display("burst length done");
  endtask

  task automatic t_power_down;
    u_ctrl.send(P_NOP, 1'b0, 3'h0, 16'h0000);
    u_ctrl.send(P_WR, 1'b0, 3'h1, 16'h0000);
    chk(cmd_code === power_down_entry_cmd && power_state === mode_power_down, "power-down entry");
    u_ctrl.send(P_DES, 1'b1, 3'h0, 16'h0000);
    chk(cmd_valid === 1'b0 && power_state === mode_power_down, "command taken in power-down");
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_code === power_down_exit_cmd && power_state === mode_normal, "power-down exit");
    idle(2);
    $display("power down done");
  endtask

  task automatic t_self_refresh;
    idle(6);
    chk(termination_enable === 1'b1, "termination off in normal");
    u_ctrl.send(P_REF, 1'b0, 3'h0, 16'h0000);
    u_ctrl.send(P_NOP, 1'b0, 3'h0, 16'h0000);
    chk(cmd_code === self_refresh_entry_cmd && power_state === mode_self_refresh, "self-refresh entry");
    u_ctrl.send(P_NOP, 1'b0, 3'h0, 16'h0000);
    chk(termination_enable === 1'b0, "termination on in self-refresh");
    u_ctrl.send(P_DES, 1'b1, 3'h0, 16'h0000);
    cmd(P_NOP, 3'h0, 16'h0000);
    chk(cmd_code === self_refresh_exit_cmd && power_state === mode_normal, "self-refresh exit");
    idle(2);
    chk(termination_enable === 1'b1, "termination not restored");
    $display("self refresh done");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    idle(2);
    t_decode();
    t_write_burst();
    t_burst_length();
    t_power_down();
    t_self_refresh();
    wrap_up();
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
